/* File: src/plc_pkg.sv */
// Operation
// R01: Bus-A pattern bit 8 inverted when set
// R02: Pattern control changed only while disabled
// R03: Enable bit: 0 disables, 1 enables; reset 1
// R04: Disable interface before changing other configuration
// R05: Disabled interface held reset, outputs down, gated
// R06: Disabled: frame counter reset, sysref ignored
// R07: Calibration enabled before interface enabled
// R08: Interface disabled before calibration disabled
// R09: Mode register written only while disabled
// R10: Width select: 12, 11, 10, 8 bits
// R11: Interleave bit: 0 dual, 1 single; reset 0
// R12: Calibration off before changing interleave bit
// R13: Align bit: 0 staggered buses, 1 aligned
// R14: Demux bit: 0 two buses, 1 four; reset 1
// R15: Frame length multiples of four, 4..128
// R16: Unit interval is one or two clocks
// R17: Strobe period follows programmed frame length
// R18: Software avoids frame length of four
// R19: Software sync request bit, reset to 1
// R20: Writing 0 requests sync like hardware input
// R21: Counter wraps per frame, strobe marks boundary
package plc_pkg;
  localparam int        WB_ADR_W       = 12;
  localparam int        WB_DAT_W       = 32;
  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_ENABLE    = 10'h200;
  localparam logic [9:0] IDX_MODE      = 10'h201;
  localparam logic [9:0] IDX_FRAME     = 10'h202;
  localparam logic [9:0] IDX_SYNC      = 10'h203;
  localparam logic [9:0] IDX_PATTERN   = 10'h190;
  localparam logic [9:0] IDX_STATUS    = 10'h2f0;
  localparam logic [7:0] RST_ENABLE    = 8'h01;
  localparam logic [7:0] RST_MODE      = 8'h01;
  localparam logic [7:0] RST_FRAME     = 8'h80;
  localparam logic [7:0] RST_SYNC      = 8'h01;
  localparam logic [7:0] RST_PATTERN   = 8'h1e;
  localparam int        POS_WIDTH      = 4;
  localparam int        POS_INTERLEAVE = 2;
  localparam int        POS_ALIGN      = 1;
  localparam int        POS_DEMUX      = 0;
  localparam int        POS_INV_A      = 0;
  localparam int        PAT_CTRL_W     = 5;
  localparam int        INV_A_BIT      = 8;
  localparam int        PATTERN_W      = 12;
  localparam int        NUM_BUSES      = 4;
  localparam logic [3:0] BUSES_DEMUX1  = 4'h3;
  localparam logic [3:0] BUSES_DEMUX2  = 4'hf;

  typedef struct packed {
    logic [1:0] sample_width_sel;
    logic       interleave;
    logic       bus_align_sel;
    logic       demux_factor_sel;
  } mode_t;

  typedef struct packed {
    logic [7:0] ui_count;
    logic       sync_active;
    logic       link_active;
  } link_status_t;
endpackage

/* File: src/frame_strobe_counter.sv */
`timescale 1ns/1ps
module frame_strobe_counter
  import plc_pkg::*;
#(
  parameter int LEN_W = 8
) (
  input  wire logic             i_clock,
  input  wire logic             i_resetn,
  input  wire logic             i_enable,
  input  wire logic             i_clock_edge,
  input  wire logic             i_two_edges,
  input  wire logic [LEN_W-1:0] i_frame_length,
  input  wire logic             i_realign,
  output logic                  o_frame_strobe,
  output logic [LEN_W-1:0]      o_ui_count
);
  logic phase;
  logic ui_done;

  assign ui_done = i_clock_edge && (!i_two_edges || phase);  // [R16]

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      phase          <= 1'b0;
      o_ui_count     <= '0;
      o_frame_strobe <= 1'b0;
    end else if (!i_enable || i_realign) begin  // [R06]
      phase          <= 1'b0;
      o_ui_count     <= '0;
      o_frame_strobe <= 1'b0;
    end else begin
      o_frame_strobe <= 1'b0;
      if (i_clock_edge) begin
        phase <= i_two_edges && !phase;
      end
      if (ui_done) begin
        if (o_ui_count == i_frame_length - 1'b1) begin  // [R17]
          o_ui_count     <= '0;
          o_frame_strobe <= 1'b1;  // [R21]
        end else begin
          o_ui_count <= o_ui_count + 1'b1;
        end
      end
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);

  strobe_when_enabled_a: assert property (o_frame_strobe |-> $past(i_enable))  // [R06]
    else $error("Frame strobe while disabled");
  held_when_off_a: assert property (!i_enable |=> o_ui_count == '0 && !o_frame_strobe)  // [R06]
    else $error("Frame counter not held while disabled");
  strobe_at_wrap_a: assert property (o_frame_strobe |-> o_ui_count == '0 && $past(o_ui_count) ==  // [R21]
    $past(i_frame_length) - 1'b1)
    else $error("Strobe not at frame wrap");
endmodule

/* File: src/parallel_output_link_config.sv */
`timescale 1ns/1ps
module parallel_output_link_config
  import plc_pkg::*;
(
  input  wire logic                  i_clock,
  input  wire logic                  i_resetn,
  input  wire logic                  i_wb_cyc,
  input  wire logic                  i_wb_stb,
  input  wire logic                  i_wb_we,
  input  wire logic [WB_ADR_W-1:0]   i_wb_adr,
  input  wire logic [3:0]            i_wb_sel,
  input  wire logic [WB_DAT_W-1:0]   i_wb_dat,
  output logic [WB_DAT_W-1:0]        o_wb_dat,
  output logic                       o_wb_ack,
  input  wire logic                  i_link_clock,
  input  wire logic                  i_sync_n,
  input  wire logic                  i_sysref,
  input  wire logic [PATTERN_W-1:0]  i_pattern,
  output logic [PATTERN_W-1:0]       o_bus_a_pattern,
  output logic                       o_link_reset_n,
  output logic [NUM_BUSES-1:0]       o_bus_enable,
  output logic [NUM_BUSES-1:0]       o_bus_clock,
  output logic                       o_frame_strobe,
  output logic                       o_sync_request,
  output mode_t                      o_mode,
  output logic [3:0]                 o_sample_bits,
  output logic [7:0]                 o_frame_length
);
  // Pin synchronisers; first stages feed only second stages
  logic       link_clock_meta;
  logic       link_clock_sync;
  logic       link_clock_last;
  logic       sync_n_meta;
  logic       sync_n_sync;
  logic       sysref_meta;
  logic       sysref_sync;
  logic       sysref_last;
  logic       link_edge;
  logic       sysref_rise;

  logic       link_enable;
  mode_t      mode;
  logic [7:0] frame_length;
  logic       soft_sync_request_n;
  logic [PAT_CTRL_W-1:0] test_pattern_control;
  logic       pattern_invert_bus_a;

  logic       bus_request;
  logic       bus_write;
  logic [9:0] reg_index;
  logic       next_sync;
  logic [7:0] ui_count;
  logic       strobe;
  link_status_t status;
  logic [NUM_BUSES-1:0] active_buses;

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      link_clock_meta <= 1'b0;
      link_clock_sync <= 1'b0;
      link_clock_last <= 1'b0;
    end else begin
      link_clock_meta <= i_link_clock;
      link_clock_sync <= link_clock_meta;
      link_clock_last <= link_clock_sync;
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      sync_n_meta <= 1'b1;
      sync_n_sync <= 1'b1;
    end else begin
      sync_n_meta <= i_sync_n;
      sync_n_sync <= sync_n_meta;
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      sysref_meta <= 1'b0;
      sysref_sync <= 1'b0;
      sysref_last <= 1'b0;
    end else begin
      sysref_meta <= i_sysref;
      sysref_sync <= sysref_meta;
      sysref_last <= sysref_sync;
    end
  end

  assign link_edge   = link_clock_sync && !link_clock_last;
  // Sysref only realigns a running interface
  assign sysref_rise = sysref_sync && !sysref_last && link_enable;  // [R06]

  // Wishbone classic slave, answer one cycle after request
  assign bus_request = i_wb_cyc && i_wb_stb && !o_wb_ack;
  assign bus_write   = bus_request && i_wb_we && i_wb_sel[0];
  assign reg_index   = i_wb_adr[WB_ADR_W-1:2];

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_wb_ack <= 1'b0;
    end else begin
      o_wb_ack <= bus_request;
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      link_enable <= RST_ENABLE[0];  // [R03]
    end else if (bus_write && reg_index == IDX_ENABLE) begin
      link_enable <= i_wb_dat[0];  // [R03]
    end
  end

  // Writes while enabled still land; keeping order is software's job
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      mode <= mode_t'({RST_MODE[5:4], RST_MODE[2:0]});
    end else if (bus_write && reg_index == IDX_MODE) begin  // [R09]
      mode.sample_width_sel <= i_wb_dat[POS_WIDTH+:2];  // [R10]
      mode.interleave       <= i_wb_dat[POS_INTERLEAVE];  // [R11]
      mode.bus_align_sel    <= i_wb_dat[POS_ALIGN];  // [R13]
      mode.demux_factor_sel <= i_wb_dat[POS_DEMUX];  // [R14]
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      frame_length <= RST_FRAME;
    end else if (bus_write && reg_index == IDX_FRAME) begin
      frame_length <= i_wb_dat[7:0];  // [R15]
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      soft_sync_request_n <= RST_SYNC[0];  // [R19]
    end else if (bus_write && reg_index == IDX_SYNC) begin
      soft_sync_request_n <= i_wb_dat[0];  // [R20]
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      test_pattern_control <= RST_PATTERN[PAT_CTRL_W-1:0];
    end else if (bus_write && reg_index == IDX_PATTERN) begin  // [R02]
      test_pattern_control <= i_wb_dat[PAT_CTRL_W-1:0];
    end
  end

  assign pattern_invert_bus_a = test_pattern_control[POS_INV_A];

  always_comb begin
    status             = '0;
    status.ui_count    = ui_count;
    status.sync_active = o_sync_request;
    status.link_active = link_enable;
  end

  // Unmapped addresses answer with zero data and ignore writes
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_wb_dat <= '0;
    end else if (bus_request) begin
      case (reg_index)
        IDX_ENABLE:  o_wb_dat <= {31'h0, link_enable};
        IDX_MODE:    o_wb_dat <= {26'h0, mode.sample_width_sel, 1'b0, mode.interleave,
                                  mode.bus_align_sel, mode.demux_factor_sel};
        IDX_FRAME:   o_wb_dat <= {24'h0, frame_length};
        IDX_SYNC:    o_wb_dat <= {31'h0, soft_sync_request_n};
        IDX_PATTERN: o_wb_dat <= {27'h0, test_pattern_control};
        IDX_STATUS:  o_wb_dat <= {22'h0, status};
        default:     o_wb_dat <= '0;
      endcase
    end
  end

  // Link-facing side, held in reset while disabled except the mode, sample width and frame length copies
  frame_strobe_counter #(
    .LEN_W(8)
  ) frame_strobe_counter_inst (
    .i_clock        (i_clock),
    .i_resetn       (i_resetn),
    .i_enable       (link_enable),
    .i_clock_edge   (link_edge),
    .i_two_edges    (mode.demux_factor_sel),
    .i_frame_length (frame_length),
    .i_realign      (sysref_rise),
    .o_frame_strobe (strobe),
    .o_ui_count     (ui_count)
  );

  // Either the pin or the software bit requests sync
  assign next_sync = link_enable && (!soft_sync_request_n || !sync_n_sync);  // [R20]

  // Unused buses stay dark, clocks included
  assign active_buses = mode.demux_factor_sel ? BUSES_DEMUX2 : BUSES_DEMUX1;  // [R14]

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_link_reset_n <= 1'b0;
      o_sync_request <= 1'b0;
      o_frame_strobe <= 1'b0;
    end else begin
      o_link_reset_n <= link_enable;  // [R05]
      o_sync_request <= next_sync;
      o_frame_strobe <= strobe;  // [R21]
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_bus_enable <= '0;
      o_bus_clock  <= '0;
    end else if (!link_enable) begin
      o_bus_enable <= '0;  // [R05]
      o_bus_clock  <= '0;  // [R05]
    end else begin
      o_bus_enable <= active_buses;  // [R14]
      o_bus_clock  <= active_buses & {NUM_BUSES{link_clock_sync}};
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_bus_a_pattern <= '0;
    end else if (!link_enable) begin
      o_bus_a_pattern <= '0;  // [R05]
    end else begin
      o_bus_a_pattern <= i_pattern ^ (PATTERN_W'(pattern_invert_bus_a) << INV_A_BIT);  // [R01]
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_mode         <= '0;
      o_sample_bits  <= '0;
      o_frame_length <= '0;
    end else begin
      o_mode         <= mode;  // [R11] [R13]
      o_frame_length <= frame_length;  // [R17]
      case (mode.sample_width_sel)  // [R10]
        2'h0:    o_sample_bits <= 4'hc;
        2'h1:    o_sample_bits <= 4'hb;
        2'h2:    o_sample_bits <= 4'ha;
        default: o_sample_bits <= 4'h8;
      endcase
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);

  bus_ack_timing_a: assert property (bus_request |=> o_wb_ack ##1 !o_wb_ack)
    else $error("Ack not one cycle after request");
  enable_write_a: assert property (bus_write && reg_index == IDX_ENABLE |=>  // [R03]
    ##1 o_link_reset_n == $past(i_wb_dat[0], 2))
    else $error("Enable write not reflected");
  disabled_quiet_a: assert property (!link_enable |=> o_bus_enable == '0 && o_bus_a_pattern == '0  // [R05]
    && !o_link_reset_n && !o_sync_request)
    else $error("Outputs active while disabled");
  bus_count_a: assert property (link_enable && $stable(mode) |=>  // [R14]
    o_bus_enable == ($past(mode.demux_factor_sel) ? BUSES_DEMUX2 : BUSES_DEMUX1))
    else $error("Wrong number of buses");
  invert_bit8_a: assert property (link_enable |=> o_bus_a_pattern ==  // [R01]
    ($past(i_pattern) ^ ({{(PATTERN_W-1){1'b0}}, $past(pattern_invert_bus_a)} << INV_A_BIT)))
    else $error("Bus A pattern inversion wrong");
  soft_sync_a: assert property (link_enable && !soft_sync_request_n |=> o_sync_request)  // [R20]
    else $error("Software sync request ignored");
  width_map_a: assert property (mode.sample_width_sel == 2'h3 |=> o_sample_bits == 4'h8)  // [R10]
    else $error("Sample width map wrong");
  frame_period_a: assert property (strobe && link_enable && !mode.demux_factor_sel &&  // [R17]
    frame_length == 8'h08 |=> !strobe [*3])
    else $error("Strobe period too short");

  // Register writes land on the edge that raises ack
  mode_write_a: assert property (bus_write && reg_index == IDX_MODE |=>  // [R10] [R11] [R13] [R14]
    mode == mode_t'({$past(i_wb_dat[POS_WIDTH+:2]), $past(i_wb_dat[POS_INTERLEAVE]),
                     $past(i_wb_dat[POS_ALIGN]), $past(i_wb_dat[POS_DEMUX])}))
    else $error("Mode write not reflected");
  frame_write_a: assert property (bus_write && reg_index == IDX_FRAME |=>  // [R17]
    frame_length == $past(i_wb_dat[7:0]))
    else $error("Frame length write not reflected");
  sync_write_a: assert property (bus_write && reg_index == IDX_SYNC |=>  // [R20]
    soft_sync_request_n == $past(i_wb_dat[0]))
    else $error("Sync bit write not reflected");
  pattern_write_a: assert property (bus_write && reg_index == IDX_PATTERN |=>  // [R01]
    test_pattern_control == $past(i_wb_dat[PAT_CTRL_W-1:0]))
    else $error("Pattern control write not reflected");
  lane_refused_a: assert property (bus_request && i_wb_we && !i_wb_sel[0] |=>  // [R17]
    $stable(frame_length))
    else $error("Write without lane zero landed");

  // Sync request follows the pin and the software bit; sysref rise realigns the frame counter
  pin_sync_a: assert property (link_enable && !sync_n_sync |=>  // [R20]
    o_sync_request)
    else $error("Pin sync request ignored");
  sync_idle_a: assert property (soft_sync_request_n && sync_n_sync |=>  // [R20]
    !o_sync_request)
    else $error("Sync request without a source");
  sysref_realign_a: assert property (sysref_rise |=>  // [R06]
    ui_count == '0 && !strobe)
    else $error("Sysref did not realign frame counter");

  bus_clock_gate_a: assert property ((o_bus_clock & ~o_bus_enable) == '0)  // [R05]
    else $error("Clock on a disabled bus");
  link_reset_a: assert property (1'b1 |=>  // [R05]
    o_link_reset_n == $past(link_enable))
    else $error("Link reset does not follow enable");
  mode_copy_a: assert property (1'b1 |=>  // [R11] [R13]
    o_mode == $past(mode))
    else $error("Mode output stale");
  frame_copy_a: assert property (1'b1 |=>  // [R17]
    o_frame_length == $past(frame_length))
    else $error("Frame length output stale");
  strobe_copy_a: assert property (1'b1 |=>  // [R21]
    o_frame_strobe == $past(strobe))
    else $error("Frame strobe not passed on");
  width_12_a: assert property (mode.sample_width_sel == 2'h0 |=>  // [R10]
    o_sample_bits == 4'hc)
    else $error("Sample width map wrong for 12 bits");
  width_11_a: assert property (mode.sample_width_sel == 2'h1 |=>  // [R10]
    o_sample_bits == 4'hb)
    else $error("Sample width map wrong for 11 bits");
  width_10_a: assert property (mode.sample_width_sel == 2'h2 |=>  // [R10]
    o_sample_bits == 4'ha)
    else $error("Sample width map wrong for 10 bits");

  // Read data stands with ack
  read_enable_a: assert property (bus_request && !i_wb_we && reg_index == IDX_ENABLE |=>  // [R03]
    o_wb_dat == {31'h0, $past(link_enable)})
    else $error("Enable read back wrong");
  read_status_a: assert property (bus_request && !i_wb_we && reg_index == IDX_STATUS |=>  // [R03]
    o_wb_dat[0] == $past(link_enable))
    else $error("Status enable bit wrong");
  ack_on_request_a: assert property (o_wb_ack |->
    $past(bus_request))
    else $error("Ack without request");

  cover_strobe_c: cover property (link_enable ##[1:200] o_frame_strobe);
  cover_sync_c: cover property (!soft_sync_request_n && link_enable ##1 o_sync_request);
  cover_disable_c: cover property (link_enable ##1 !link_enable);
  cover_demux2_c: cover property (mode.demux_factor_sel && link_enable ##[1:300] o_frame_strobe);
  cover_realign_c: cover property (sysref_rise);
endmodule

/* File: verif/link_receiver_model.sv */
`timescale 1ns/1ps
module link_receiver_model (
  input  wire logic  i_clock,
  input  wire logic  i_frame_strobe,
  output logic       o_link_clock,
  output logic [8:0] o_frame_edges,
  output logic [7:0] o_strobes
);
  logic       prev;
  logic [8:0] edges;
  // Output clock follows the sample clock, so it runs free; phase unrelated
  initial begin
    o_link_clock = 1'b0;
    #13;
    forever #200 o_link_clock = ~o_link_clock;
  end
  // Link clock edges seen per frame
  initial begin
    prev = 1'b0;
    edges = '0;
    o_frame_edges = '0;
    o_strobes = '0;
  end
  always @(posedge i_clock) begin
    prev <= o_link_clock;
    if (i_frame_strobe) begin
      o_frame_edges <= edges + 9'(o_link_clock & ~prev);
      edges <= '0;
      o_strobes <= o_strobes + 8'h01;
    end else if (o_link_clock & ~prev) begin
      edges <= edges + 9'h001;
    end
  end
endmodule

/* File: verif/parallel_output_link_config_bench.sv */
`timescale 1ns/1ps
module parallel_output_link_config_bench;
  import plc_pkg::*;
  logic                 i_clock, i_resetn, cyc, stb, we, sync_n, sysref;
  logic [WB_ADR_W-1:0]  adr;
  logic [WB_DAT_W-1:0]  wdat, o_wb_dat, rd;
  logic                 o_wb_ack, link_clk, o_link_reset_n, o_frame_strobe, o_sync_request;
  logic [PATTERN_W-1:0] pattern, o_bus_a_pattern;
  logic [3:0]           o_bus_enable, o_bus_clock, o_sample_bits, sel;
  logic [7:0]           o_frame_length, strobes;
  logic [8:0]           frame_edges;
  mode_t                o_mode;
  int                   num_errors, checks_done, cycles, i;
  parallel_output_link_config parallel_output_link_config_inst (.i_clock(i_clock), .i_resetn(i_resetn),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
    .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_link_clock(link_clk), .i_sync_n(sync_n),
    .i_sysref(sysref), .i_pattern(pattern), .o_bus_a_pattern(o_bus_a_pattern),
    .o_link_reset_n(o_link_reset_n), .o_bus_enable(o_bus_enable), .o_bus_clock(o_bus_clock),
    .o_frame_strobe(o_frame_strobe), .o_sync_request(o_sync_request), .o_mode(o_mode),
    .o_sample_bits(o_sample_bits), .o_frame_length(o_frame_length));
  link_receiver_model link_receiver_model_inst (.i_clock(i_clock), .i_frame_strobe(o_frame_strobe),
    .o_link_clock(link_clk), .o_frame_edges(frame_edges), .o_strobes(strobes));
  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end
  task automatic test_done;
    if (num_errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      num_errors++;
      test_done();
    end
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Holds the request until ack is seen, releases at that edge, idles one cycle
  task automatic wb(input logic w, input logic [9:0] idx, input logic [7:0] d);
    int n;
    @(posedge i_clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h0, d};
    n = 0;
    do begin
      @(posedge i_clock);
      n++;
    end while (o_wb_ack !== 1'b1 && n < 20);
    chk("ack", 1, n < 20);
    rd = o_wb_dat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge i_clock);
  endtask
  // Disable first, then reconfigure, then enable again
  task automatic cfg(input logic [7:0] mode, input logic [7:0] len, input logic [7:0] pat);
    wb(1, IDX_ENABLE, 8'h00);
    wb(1, IDX_MODE, mode);
    wb(1, IDX_FRAME, len);
    wb(1, IDX_PATTERN, pat);
    wb(1, IDX_ENABLE, 8'h01);
    repeat (4) @(posedge i_clock);
  endtask
  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    sysref = 1'b0;
    sel = 4'h1;
    num_errors = 0;
    checks_done = 0;
    cycles = 0;
    adr = '0;
    wdat = '0;
    sync_n = 1'b1;
    pattern = 12'ha5a;
    i_resetn = 1'b0;
    repeat (20) @(posedge i_clock);
    i_resetn <= 1'b1;
    repeat (3) @(posedge i_clock);
    chk("link_reset_n", 1, o_link_reset_n);
    chk("bus_enable", 4'hf, o_bus_enable);
    chk("sample_bits", 12, o_sample_bits);
    chk("bus_a", 12'ha5a, o_bus_a_pattern);
    wb(0, IDX_ENABLE, 0);
    chk("enable rst", 8'h01, rd);
    wb(0, IDX_MODE, 0);
    chk("mode rst", 8'h01, rd);
    wb(0, IDX_FRAME, 0);
    chk("frame rst", 8'h80, rd);
    wb(0, IDX_SYNC, 0);
    chk("sync rst", 8'h01, rd);
    wb(0, IDX_PATTERN, 0);
    chk("pattern rst", 8'h1e, rd);
    sel <= 4'h0;
    wb(1, IDX_FRAME, 8'h10);
    sel <= 4'h1;
    wb(0, IDX_FRAME, 0);
    chk("sel refused", 8'h80, rd);
    wb(0, 10'h3ff, 0);
    chk("unmapped", 0, rd);
    cfg(8'h00, 8'h08, 8'h01);
    chk("bus_a inv", 12'hb5a, o_bus_a_pattern);
    chk("bus_enable", 4'h3, o_bus_enable);
    repeat (200) @(posedge i_clock);
    chk("ui per frame", 8, frame_edges);
    cfg(8'h01, 8'h08, 8'h00);
    repeat (400) @(posedge i_clock);
    chk("ui demux2", 16, frame_edges);
    cfg(8'h00, 8'h0c, 8'h00);
    repeat (500) @(posedge i_clock);
    chk("frame 12", 12, frame_edges);
    chk("frame len", 8'h0c, o_frame_length);
    for (i = 0; i < 4; i++) begin
      cfg({2'b00, 2'(i), 1'b0, 2'(i), 1'b1}, 8'h80, 8'h00);
      chk("mode", {2'(i), 2'(i), 1'b1}, o_mode);
      chk("sample_bits", i == 0 ? 12 : i == 1 ? 11 : i == 2 ? 10 : 8, o_sample_bits);
    end
    wb(1, IDX_ENABLE, 8'h00);
    repeat (4) @(posedge i_clock);
    chk("disabled", 0, {o_link_reset_n, o_bus_enable, o_bus_clock, o_bus_a_pattern});
    rd = {24'h0, strobes};
    sysref <= 1'b1;
    repeat (5) @(posedge i_clock);
    sysref <= 1'b0;
    repeat (100) @(posedge i_clock);
    chk("strobes held", rd, {24'h0, strobes});
    wb(1, IDX_ENABLE, 8'h01);
    repeat (64) @(posedge i_clock);
    sysref <= 1'b1;
    repeat (5) @(posedge i_clock);
    sysref <= 1'b0;
    wb(0, IDX_STATUS, 0);
    chk("status realigned", 32'h1, rd);
    wb(1, IDX_SYNC, 8'h00);
    repeat (2) @(posedge i_clock);
    chk("soft sync", 1, o_sync_request);
    wb(1, IDX_SYNC, 8'h01);
    repeat (2) @(posedge i_clock);
    chk("sync off", 0, o_sync_request);
    sync_n <= 1'b0;
    repeat (6) @(posedge i_clock);
    chk("pin sync", 1, o_sync_request);
    test_done();
  end
endmodule
